// file: rtl/mode_ctrl_pkg.sv
// constants for the serial mode control block
package mode_ctrl_pkg;
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam int BIT_PORT_EN = 15;
  localparam int BIT_IDLE_STOP = 13;
  localparam int BIT_IR_EN = 12;
  localparam int BIT_RTS_MD = 11;
  localparam int BIT_PIN_HI = 9;
  localparam int BIT_PIN_LO = 8;
  localparam int BIT_WAKE = 7;
  localparam int BIT_LOOP = 6;
  localparam int BIT_AUTO_RATE_DETECT_ARM = 5;
  localparam int BIT_RXINV = 4;
  localparam int BIT_HSPEED = 3;
  localparam logic [15:0] MODE_WMASK = 16'hbbff;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [1:0] PINS_TXRX = 2'h0;
  localparam logic [1:0] PINS_RTS = 2'h1;
  localparam logic [1:0] PINS_CTS_RTS = 2'h2;
  localparam logic [1:0] PINS_BCLK = 2'h3;
  localparam logic [7:0] SYNC_CHAR = 8'h55;
  localparam int SYNC_EDGES = 5;
  localparam logic [3:0] IR_PULSE = 4'h3;
  localparam logic [3:0] BIT_TICKS = 4'hf;
endpackage : mode_ctrl_pkg

// file: rtl/rate_measure.sv
// auto-rate measurement over the sync character
`timescale 1ns/10ps
module rate_measure (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic arm_i,
  input wire logic rx_i,
  output logic done_o,
  output logic [15:0] period_o
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_COUNT = 3'b010,
    S_DONE = 3'b100
  } meas_type;
  meas_type state_ff;
  logic [15:0] cnt_ff;
  logic [2:0] falls_ff;
  logic rx_d_ff;
  wire fall = rx_d_ff & ~rx_i;
  wire [15:0] cnt_inc = cnt_ff + 16'h0001;
  always_ff @(posedge clk_i) begin
    rx_d_ff <= rst_i ? 1'b1 : rx_i;
  end
  // five falling edges of the sync character span eight bit times
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= S_IDLE;
      cnt_ff <= 16'h0000;
      falls_ff <= 3'h0;
      done_o <= 1'b0;
      period_o <= 16'h0000;
    end else begin
      done_o <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          cnt_ff <= 16'h0000;
          falls_ff <= 3'h0;
          if (arm_i && fall) begin
            state_ff <= S_COUNT;
          end
        end
        S_COUNT: begin
          cnt_ff <= cnt_inc;
          if (!arm_i) begin
            state_ff <= S_IDLE;
          end else if (fall) begin
            falls_ff <= falls_ff + 3'h1;
            if (falls_ff == 3'(mode_ctrl_pkg::SYNC_EDGES - 2)) begin
              state_ff <= S_DONE;
              // count the closing edge too, or the period comes out one short
              period_o <= {3'h0, cnt_inc[15:3]};
            end
          end
        end
        S_DONE: begin
          done_o <= 1'b1;
          state_ff <= S_IDLE;
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end
endmodule : rate_measure

// file: rtl/serial_mode_control.sv
// mode register, pin ownership, wake, loopback, infrared and auto-rate
// Contract
// R1: handshake_out_mode_select 1 drives request-to-send as simplex, 0 as receive flow control.
// R2: pin field 10 uses tx, rx, cts and rts; 01 uses tx, rx and rts with cts to the latch.
// R3: pin field 11 uses tx, rx and baud clock out; 00 uses only tx and rx.
// R4: with wake enabled rx is sampled in sleep and a falling start edge raises an interrupt.
// R5: after the wake interrupt the wake bit clears itself on the next rising rx edge.
// R6: loop select 1 loops transmit back to receive, 0 returns to normal.
// R7: infrared enable 0 bypasses the codec.
// R8: infrared enable 1 routes tx through the encoder and rx through the decoder.
// R9: software enables infrared only with high speed select at 0.
// R10: port enable 0 releases every pin to the latches, 1 follows the pin field.
// R11: armed auto-rate measures the 0x55 sync character and clears its bit when done.
//
// Added by the designer: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
module serial_mode_control (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] adr_i,
  input wire logic [15:0] dat_i,
  output logic [15:0] dat_o,
  input wire logic we_i,
  input wire logic [1:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  output logic err_o,
  input wire logic sleep_i,
  input wire logic tx_data_i,
  input wire logic rts_ready_i,
  input wire logic tx_busy_i,
  input wire logic bclk_i,
  input wire logic serial_receive_pin_i,
  input wire logic clear_send_pin_i,
  output logic serial_transmit_pin_o,
  output logic request_send_pin_o,
  output logic request_send_oe_n_o,
  output logic tx_oe_n_o,
  output logic rx_data_o,
  output logic cts_o,
  output logic wake_irq_o,
  output logic rate_done_o,
  output logic [15:0] rate_period_o
);
  logic [15:0] mode_ff;
  logic [15:0] nxt_mode;
  logic rx_s1_ff;
  logic rx_s2_ff;
  logic rx_d_ff;
  logic cts_s1_ff;
  logic cts_s2_ff;
  logic wake_seen_ff;
  logic [3:0] ir_cnt_ff;
  logic ack_ff;
  logic meas_done;
  logic [15:0] meas_period;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  // err is one cycle too: a request still held must not be refused twice
  wire access = cyc_i & stb_i & ~ack_ff & ~err_o;
  wire hit_mode = adr_i == mode_ctrl_pkg::ADDR_MODE;
  wire hit_stat = adr_i == mode_ctrl_pkg::ADDR_STATUS;
  wire mapped = hit_mode | hit_stat;
  wire wr_mode = access & we_i & hit_mode;
  wire [15:0] lane_mask = {{8{sel_i[1]}}, {8{sel_i[0]}}} & mode_ctrl_pkg::MODE_WMASK;
  wire port_en = mode_ff[mode_ctrl_pkg::BIT_PORT_EN];
  wire [1:0] pin_use = mode_ff[mode_ctrl_pkg::BIT_PIN_HI:mode_ctrl_pkg::BIT_PIN_LO];
  wire ir_en = mode_ff[mode_ctrl_pkg::BIT_IR_EN];
  wire loop_en = mode_ff[mode_ctrl_pkg::BIT_LOOP];
  wire auto_rate_detect_arm = mode_ff[mode_ctrl_pkg::BIT_AUTO_RATE_DETECT_ARM];
  wire rx_inv = mode_ff[mode_ctrl_pkg::BIT_RXINV];
  wire wake_en = mode_ff[mode_ctrl_pkg::BIT_WAKE];
  wire [15:0] status = {13'h0000, wake_seen_ff, rx_s2_ff, auto_rate_detect_arm};

  ////////////////////////////////////////////////////////////////////////////
  // pin ownership
  wire own_rts = port_en & ((pin_use == mode_ctrl_pkg::PINS_RTS) |
                 (pin_use == mode_ctrl_pkg::PINS_CTS_RTS)); // see R2 see R10
  wire own_bclk = port_en & (pin_use == mode_ctrl_pkg::PINS_BCLK); // see R3
  wire own_cts = port_en & (pin_use == mode_ctrl_pkg::PINS_CTS_RTS); // see R2 see R3
  // simplex asserts (low) while sending, flow control while ready to take data
  wire rts_level = mode_ff[mode_ctrl_pkg::BIT_RTS_MD] ? ~tx_busy_i : ~rts_ready_i; // see R1
  wire rx_plain = rx_s2_ff ^ rx_inv;
  wire tx_ir = ~((ir_cnt_ff < mode_ctrl_pkg::IR_PULSE) & ~tx_data_i); // see R8
  wire tx_line = ir_en ? tx_ir : tx_data_i; // see R7
  // decoder only inverts the line, so a high pulse reads low for its own length; idle-low ir line assumed
  wire rx_dec = ir_en ? ~rx_plain : rx_plain; // see R8 see R7
  wire rx_in = loop_en ? tx_data_i : rx_dec; // see R6
  wire wake_fall = rx_d_ff & ~rx_s2_ff;
  wire wake_rise = ~rx_d_ff & rx_s2_ff;

  ////////////////////////////////////////////////////////////////////////////
  // mode register; hardware clears win over a same-cycle write
  always_comb begin
    nxt_mode = mode_ff;
    if (wr_mode) begin
      nxt_mode = (mode_ff & ~lane_mask) | (dat_i & lane_mask);
    end
    if (wake_seen_ff && wake_rise) begin
      nxt_mode[mode_ctrl_pkg::BIT_WAKE] = 1'b0; // see R5
    end
    if (meas_done) begin
      nxt_mode[mode_ctrl_pkg::BIT_AUTO_RATE_DETECT_ARM] = 1'b0; // see R11
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_ff <= mode_ctrl_pkg::MODE_RESET;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // pins reset to their idle level so no false edge follows reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
      rx_d_ff <= 1'b1;
      cts_s1_ff <= 1'b1;
      cts_s2_ff <= 1'b1;
    end else begin
      rx_s1_ff <= serial_receive_pin_i;
      rx_s2_ff <= rx_s1_ff;
      rx_d_ff <= rx_s2_ff;
      cts_s1_ff <= clear_send_pin_i;
      cts_s2_ff <= cts_s1_ff;
    end
  end

  // bus answer: one-cycle ack or err, read data registered with it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 16'h0000;
    end else begin
      ack_ff <= access & mapped;
      err_o <= access & ~mapped;
      dat_o <= hit_stat ? status : mode_ff;
    end
  end
  assign ack_o = ack_ff;

  ////////////////////////////////////////////////////////////////////////////
  // wake on start edge, sampled even in sleep
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_seen_ff <= 1'b0;
      wake_irq_o <= 1'b0;
    end else begin
      wake_irq_o <= wake_en & sleep_i & wake_fall & ~wake_seen_ff; // see R4
      if (wake_en & sleep_i & wake_fall) begin
        wake_seen_ff <= 1'b1; // see R4
      end else if (wake_rise | ~wake_en) begin
        wake_seen_ff <= 1'b0; // see R5
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ir pulse timer: short pulse at start of each 16-tick bit, needs 16x mode (see R9)
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ir_cnt_ff <= 4'h0;
    end else if (bclk_i) begin
      ir_cnt_ff <= (ir_cnt_ff == mode_ctrl_pkg::BIT_TICKS) ? 4'h0 : ir_cnt_ff + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_transmit_pin_o <= 1'b1;
      tx_oe_n_o <= 1'b1;
    end else begin
      serial_transmit_pin_o <= loop_en ? 1'b1 : tx_line; // see R6
      tx_oe_n_o <= ~port_en; // see R10
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      request_send_pin_o <= 1'b1;
      request_send_oe_n_o <= 1'b1;
    end else begin
      request_send_pin_o <= own_bclk ? bclk_i : rts_level; // see R1 see R3
      request_send_oe_n_o <= ~(own_rts | own_bclk); // see R2 see R3
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_data_o <= 1'b1;
      cts_o <= 1'b0;
    end else begin
      // while measuring, the sync character is kept out of the data path
      rx_data_o <= (auto_rate_detect_arm | ~port_en) ? 1'b1 : rx_in; // see R11
      cts_o <= own_cts ? ~cts_s2_ff : 1'b1; // see R2
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rate_done_o <= 1'b0;
      rate_period_o <= 16'h0000;
    end else begin
      rate_done_o <= meas_done;
      if (meas_done) begin
        rate_period_o <= meas_period; // see R11
      end
    end
  end

  rate_measure u_meas (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .arm_i(auto_rate_detect_arm & port_en),
    .rx_i(rx_in),
    .done_o(meas_done),
    .period_o(meas_period)
  );
endmodule : serial_mode_control

// file: sim/serial_peer.sv
// remote serial peer sending one frame on the receive line
`timescale 1ns/10ps
module serial_peer #(
  parameter int BIT_CYC = 16
) (
  input wire logic clk_i,
  input wire logic send_i,
  input wire logic [7:0] byte_i,
  output logic rx_o
);
  logic [9:0] frame;
  initial rx_o = 1'b1;
  // start low, data lsb first, stop high; line idles high between frames
  always @(posedge clk_i) begin
    if (send_i) begin
      frame = {1'b1, byte_i, 1'b0};
      for (int i = 0; i < 10; i++) begin
        rx_o <= frame[i];
        repeat (BIT_CYC) @(posedge clk_i);
      end
    end
  end
endmodule : serial_peer

// file: sim/serial_mode_control_chk.sv
// port assertions for the serial mode control block
`timescale 1ns/10ps
module serial_mode_control_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] adr_i,
  input wire logic [15:0] dat_i,
  input wire logic we_i,
  input wire logic [1:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic err_o,
  input wire logic wake_irq_o,
  input wire logic rate_done_o,
  input wire logic tx_oe_n_o,
  input wire logic request_send_oe_n_o,
  input wire logic serial_transmit_pin_o
);
  logic [15:0] sh_ff;
  logic [15:0] old_ff;
  wire take = cyc_i && stb_i && !ack_o && !err_o;
  wire [15:0] wm = mode_ctrl_pkg::MODE_WMASK & {{8{sel_i[1]}}, {8{sel_i[0]}}};
  // judge pins only on a steady mode: outputs lag a write by one register
  wire steady = sh_ff == old_ff;
  wire en = sh_ff[15] && steady;
  always_ff @(posedge clk_i) begin
    old_ff <= rst_i ? 16'h0000 : sh_ff;
    if (rst_i) begin
      sh_ff <= 16'h0000;
    end else if (take && we_i && adr_i == mode_ctrl_pkg::ADDR_MODE) begin
      sh_ff <= (sh_ff & ~wm) | (dat_i & wm);
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack; take |=> ack_o || err_o; endproperty
  a_ack: assert property (p_ack) else $error("no answer");
  property p_one; ack_o || err_o |=> !ack_o && !err_o; endproperty
  a_one: assert property (p_one) else $error("answer too long");
  property p_err; take && adr_i != 4'h0 && adr_i != 4'h4 |=> err_o && !ack_o; endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_rst; $past(rst_i) |-> tx_oe_n_o && request_send_oe_n_o; endproperty
  a_rst: assert property (p_rst) else $error("pins owned at reset");
  property p_off; !sh_ff[15] && steady |-> tx_oe_n_o && request_send_oe_n_o; endproperty
  a_off: assert property (p_off) else $error("pins owned while off");
  property p_none; en && sh_ff[9:8] == 2'h0 |-> !tx_oe_n_o && request_send_oe_n_o; endproperty
  a_none: assert property (p_none) else $error("field 00 ownership");
  property p_hs; en && sh_ff[9:8] != 2'h0 |-> !request_send_oe_n_o; endproperty
  a_hs: assert property (p_hs) else $error("handshake pin not owned");
  property p_loop; en && sh_ff[6] |-> serial_transmit_pin_o; endproperty
  a_loop: assert property (p_loop) else $error("tx pin not idle in loop");
  property p_irq; wake_irq_o |=> !wake_irq_o; endproperty
  a_irq: assert property (p_irq) else $error("wake pulse too long");
  property p_done; rate_done_o |=> !rate_done_o; endproperty
  a_done: assert property (p_done) else $error("rate pulse too long");
  c_wr: cover property (take && we_i);
  c_irq: cover property (wake_irq_o);
  c_done: cover property (rate_done_o);
endmodule : serial_mode_control_chk
bind serial_mode_control serial_mode_control_chk chk (.clk_i, .rst_i, .adr_i, .dat_i,
  .we_i, .sel_i, .cyc_i, .stb_i, .ack_o, .err_o, .wake_irq_o, .rate_done_o, .tx_oe_n_o,
  .request_send_oe_n_o, .serial_transmit_pin_o);

// file: sim/tb_top.sv
// self-checking bench for the serial mode control block
`timescale 1ns/10ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("ERROR %s exp %h got %h", n, e, a); end end
module tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
  logic sleep_i = 1'b0, tx_data_i = 1'b1, rts_ready_i = 1'b0, tx_busy_i = 1'b0;
  logic bclk_i = 1'b0, clear_send_pin_i = 1'b1, send = 1'b0, e, v;
  logic [3:0] adr_i = 4'h0;
  logic [1:0] sel_i = 2'h3;
  logic [15:0] dat_i = 16'h0000, q;
  logic [7:0] byte_v = 8'h00;
  wire [15:0] dat_o, rate_period_o;
  wire ack_o, err_o, serial_receive_pin_i, serial_transmit_pin_o, request_send_pin_o;
  wire request_send_oe_n_o, tx_oe_n_o, rx_data_o, cts_o, wake_irq_o, rate_done_o;
  int num_errors = 0, n_checks = 0, cyc_cnt = 0, n_low = 0;
  serial_mode_control dut (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i,
    .stb_i, .ack_o, .err_o, .sleep_i, .tx_data_i, .rts_ready_i, .tx_busy_i, .bclk_i,
    .serial_receive_pin_i, .clear_send_pin_i, .serial_transmit_pin_o, .request_send_pin_o,
    .request_send_oe_n_o, .tx_oe_n_o, .rx_data_o, .cts_o, .wake_irq_o, .rate_done_o,
    .rate_period_o);
  serial_peer #(.BIT_CYC(16)) peer (.clk_i, .send_i(send), .byte_i(byte_v),
    .rx_o(serial_receive_pin_i));
  initial forever #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  task automatic bus(input logic [3:0] a, input logic w, input logic [15:0] d);
    adr_i <= a;
    we_i <= w;
    dat_i <= d;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
    q = dat_o;
    e = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    repeat (4) @(posedge clk_i); // idle gap also lets synced pins settle
  endtask : bus
  task automatic pulse(input logic [7:0] b);
    byte_v <= b;
    send <= 1'b1;
    @(posedge clk_i);
    send <= 1'b0;
  endtask : pulse
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    bus(4'h0, 1'b0, 16'h0000);
    `CHK("mode reset", 16'h0000, q)
    bus(4'h0, 1'b1, 16'hff57);
    bus(4'h0, 1'b0, 16'h0000);
    `CHK("mode rw", 16'hbb57, q)
    sel_i <= 2'h1;
    bus(4'h0, 1'b1, 16'h0000);
    sel_i <= 2'h3;
    bus(4'h0, 1'b0, 16'h0000);
    `CHK("lane write", 16'hbb00, q)
    bus(4'h8, 1'b0, 16'h0000);
    `CHK("unmapped", 1'b1, e)
  endtask : t_regs
  task automatic t_pins;
    for (int f = 0; f < 4; f++) begin
      bus(4'h0, 1'b1, 16'h8000 | 16'(f << 8));
      `CHK("tx oe", 1'b0, tx_oe_n_o)
      `CHK("rts oe", f == 0, request_send_oe_n_o)
      `CHK("cts", f != 2, cts_o)
    end
    bus(4'h0, 1'b1, 16'h0300);
    `CHK("off oe", 2'h3, {tx_oe_n_o, request_send_oe_n_o})
  endtask : t_pins
  task automatic t_rts;
    bus(4'h0, 1'b1, 16'h8900);
    v = request_send_pin_o;
    tx_busy_i <= 1'b1;
    bus(4'h0, 1'b0, 16'h0000);
    `CHK("simplex rts", ~v, request_send_pin_o)
    bus(4'h0, 1'b1, 16'h8100);
    v = request_send_pin_o;
    rts_ready_i <= 1'b1;
    bus(4'h0, 1'b0, 16'h0000);
    `CHK("flow rts", ~v, request_send_pin_o)
    bclk_i <= 1'b1;
    bus(4'h0, 1'b1, 16'h8300);
    `CHK("baud clock out", 1'b1, request_send_pin_o)
  endtask : t_rts
  task automatic t_loop;
    tx_data_i <= 1'b0;
    bus(4'h0, 1'b1, 16'h8040);
    `CHK("loop rx", 1'b0, rx_data_o)
    bus(4'h0, 1'b1, 16'h8000);
    `CHK("normal rx", 1'b1, rx_data_o)
    `CHK("plain tx", 1'b0, serial_transmit_pin_o)
    tx_data_i <= 1'b1;
    bus(4'h0, 1'b1, 16'h9000);
    `CHK("ir rx", 1'b0, rx_data_o)
    tx_data_i <= 1'b0;
    n_low = 0;
    repeat (2) @(posedge clk_i);
    repeat (16) begin
      @(posedge clk_i);
      n_low += (serial_transmit_pin_o === 1'b0);
    end
    `CHK("ir tx pulse", int'(mode_ctrl_pkg::IR_PULSE), n_low)
    tx_data_i <= 1'b1;
  endtask : t_loop
  task automatic t_wake;
    sleep_i <= 1'b1;
    bus(4'h0, 1'b1, 16'h8080);
    pulse(8'h00);
    for (int i = 0; i < 100 && wake_irq_o !== 1'b1; i++) @(posedge clk_i);
    `CHK("wake irq", 1'b1, wake_irq_o)
    repeat (200) @(posedge clk_i);
    bus(4'h0, 1'b0, 16'h0000);
    `CHK("wake clear", 1'b0, q[7])
    sleep_i <= 1'b0;
  endtask : t_wake
  task automatic t_baud;
    bus(4'h0, 1'b1, 16'h8020);
    pulse(8'h55);
    for (int i = 0; i < 400 && rate_done_o !== 1'b1; i++) @(posedge clk_i);
    `CHK("rate done", 1'b1, rate_done_o)
    `CHK("rate period", 16'h0010, rate_period_o)
    repeat (80) @(posedge clk_i);
    bus(4'h0, 1'b0, 16'h0000);
    `CHK("rate clear", 1'b0, q[5])
  endtask : t_baud
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_pins();
    t_rts();
    t_loop();
    t_wake();
    t_baud();
    print_verdict();
  end
endmodule : tb_top
